//--- rtl/dfg_map.svh
`ifndef DFG_MAP_SVH
`define DFG_MAP_SVH
// register byte offsets
`define DFG_CTRL      8'h00
`define DFG_STAT      8'h04
`define DFG_GEAR      8'h08
`define DFG_PSR       8'h0C
`define DFG_HSEL      8'h10
`define DFG_HIST      8'h14
`define DFG_DOCF      8'h18
`define DFG_INTG      8'h1C
`define DFG_SPOS      8'h20
`define DFG_IRQS      8'h24
`define DFG_IRQC      8'h28
`define DFG_IRQE      8'h2C
// ratio fields: numerator low half, denominator high half
`define DFG_NUM_LSB   0
`define DFG_DEN_LSB   16
// output config: two mode bits per output, level bits from here up
`define DFG_GP_LSB    16
// irq status bits
`define DFG_IRQ_FLT   0
`define DFG_IRQ_ENA   1
`define DFG_IRQ_DIS   2
// reset values
`define DFG_CTRL_RST  8'h00
`define DFG_RATIO_RST 32'h0001_0001
`define DFG_DOCF_RST  32'h0000_0000
`define DFG_INTG_RST  32'h0000_0000
// fixed primary resolution with resolver feedback
`define DFG_RES_PPR   17'h1_0000
// code raised by the inhibit path
`define DFG_INH_CODE  8'h24
// axi responses
`define DFG_OKAY      2'h0
`define DFG_SLVERR    2'h2
`endif

//--- rtl/dfg_pkg.sv
package dfg_pkg;
  typedef enum logic [1:0] {
    DFG_DIS = 2'b00,
    DFG_EN  = 2'b01,
    DFG_FLT = 2'b10
  } dfg_state_t;
  typedef struct packed {
    logic disp_default;
    logic resolver;
    logic dual_loop;
    logic pos_mode;
    logic prog_run;
    logic inhibit_fn;
    logic reset_on_enable;
    logic sw_enable;
  } dfg_ctrl_t;
  typedef struct packed {
    logic step;
    logic dir;
  } dfg_step_t;
  typedef struct packed {
    logic       show_fault;
    logic [7:0] code;
  } dfg_disp_t;
endpackage

//--- rtl/dfg_ctrl.sv
`timescale 1ns/100ps
`include "dfg_map.svh"
// Overview of operation
// RL1 - fault drops power stage and enable lamp
// RL2 - fault sets operating state to fault
// RL3 - fault code stored in history memory
// RL4 - runtime-fault outputs assert on fault
// RL5 - ready outputs deassert on fault
// RL6 - default display shows fault code
// RL7 - fault cleared on disable or re-enable
// RL8 - fault stays latched until reset condition
// RL9 - position mode follows master pulses
// RL10 - single loop scales by follower ratio
// RL11 - dual loop only in position mode
// RL12 - second ratio maps secondary to primary
// RL13 - resolver primary uses fixed 65536 count
// RL14 - secondary error feeds integral term
// RL15 - no motor drive until enabled
// RL16 - run setting, no program: positive enable
// RL17 - run setting with program: acts inhibit
// RL18 - inhibit: enable only while input active
// RL19 - inhibit: input drop disables with fault
module dfg_ctrl import dfg_pkg::*; #(
  parameter int NUM_DOUT   = 4,
  parameter int HIST_DEPTH = 8,
  parameter int POS_W      = 32
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // enable switch and fault sources
  input  wire logic              hw_enable_input,
  input  wire logic              fault_event,
  input  wire logic [7:0]        fault_code,
  // reference and feedback pulses
  input  wire dfg_step_t         master_in,
  input  wire dfg_step_t         sec_enc,
  // drive side
  output logic                   power_stage_en,
  output logic                   enable_lamp,
  output dfg_step_t              motor_cmd,
  output logic [POS_W-1:0]       integ_term,
  output logic [NUM_DOUT-1:0]    dout,
  output dfg_disp_t              fault_display_pattern,
  output logic                   irq
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  dfg_ctrl_t          ctrl;
  logic [31:0]        gear;
  logic [31:0]        psr;
  logic [31:0]        docf;
  logic [31:0]        intg;
  logic [2:0]         hsel;
  logic [2:0]         irq_stat;
  logic [2:0]         irq_en;
  dfg_state_t         state;
  dfg_state_t         next_state;
  logic [7:0]         cur_code;
  logic [7:0]         next_code;
  logic               fault_take;
  logic [7:0]         hist [HIST_DEPTH];
  logic               sw_en_q;
  logic               en_src_q;
  logic               inhibit_mode;
  logic               sw_rise;
  logic               en_src;
  logic               en_rise;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- axi write channel
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_map;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;

  always_comb begin
    if (aw_addr == `DFG_CTRL || aw_addr == `DFG_GEAR || aw_addr == `DFG_PSR) begin
      wr_map = 1'b1;
    end else if (aw_addr == `DFG_HSEL || aw_addr == `DFG_DOCF) begin
      wr_map = 1'b1;
    end else if (aw_addr == `DFG_INTG || aw_addr == `DFG_IRQC) begin
      wr_map = 1'b1;
    end else if (aw_addr == `DFG_IRQE) begin
      wr_map = 1'b1;
    end else begin
      wr_map = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DFG_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `DFG_OKAY : `DFG_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- configuration registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl   <= `DFG_CTRL_RST;
      gear   <= `DFG_RATIO_RST;
      psr    <= `DFG_RATIO_RST;
      docf   <= `DFG_DOCF_RST;
      intg   <= `DFG_INTG_RST;
      hsel   <= 3'h0;
      irq_en <= 3'h0;
    end else if (wr_fire) begin
      if (aw_addr == `DFG_CTRL) begin
        ctrl <= w_strb[0] ? dfg_ctrl_t'(w_data[7:0]) : ctrl;
      end else if (aw_addr == `DFG_GEAR) begin
        gear <= merge(gear, w_data, w_strb);
      end else if (aw_addr == `DFG_PSR) begin
        psr <= merge(psr, w_data, w_strb);
      end else if (aw_addr == `DFG_DOCF) begin
        docf <= merge(docf, w_data, w_strb);
      end else if (aw_addr == `DFG_INTG) begin
        intg <= merge(intg, w_data, w_strb);
      end else if (aw_addr == `DFG_HSEL && w_strb[0]) begin
        hsel <= w_data[2:0];
      end else if (aw_addr == `DFG_IRQE && w_strb[0]) begin
        irq_en <= w_data[2:0];
      end
    end
  end

  // ---------------- enable and fault state machine
  // a running program turns the run setting into inhibit behaviour
  assign inhibit_mode = ctrl.inhibit_fn || ctrl.prog_run; // [RL17]
  assign sw_rise      = ctrl.sw_enable && !sw_en_q;
  assign en_src       = inhibit_mode ? ctrl.sw_enable : hw_enable_input;
  assign en_rise      = en_src && !en_src_q;

  always_comb begin
    next_state = state;
    next_code  = cur_code;
    fault_take = 1'b0;
    case (state)
      DFG_DIS: begin
        if (inhibit_mode) begin
          if (sw_rise && hw_enable_input) begin
            next_state = DFG_EN; // [RL18]
          end else if (sw_rise) begin
            fault_take = 1'b1; // [RL18]
            next_code  = `DFG_INH_CODE;
          end
        end else if (hw_enable_input) begin
          next_state = DFG_EN; // [RL16]
        end
      end
      DFG_EN: begin
        if (inhibit_mode && !hw_enable_input) begin
          fault_take = 1'b1; // [RL19]
          next_code  = `DFG_INH_CODE;
        end else if (!en_src) begin
          next_state = DFG_DIS;
        end
      end
      DFG_FLT: begin
        // latched until the selected reset: enable source low, or an enable rising edge
        if (!ctrl.reset_on_enable && !en_src) begin
          next_state = DFG_DIS; // [RL7] [RL8]
        end else if (ctrl.reset_on_enable && en_rise && (!inhibit_mode || hw_enable_input)) begin
          next_state = DFG_EN; // [RL7] [RL8]
        end
      end
      default: begin
        next_state = DFG_DIS;
      end
    endcase
    // an outside fault outranks the inhibit code
    if (fault_event) begin
      fault_take = 1'b1;
      next_code  = fault_code;
    end
    if (fault_take) begin
      next_state = DFG_FLT; // [RL2]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= DFG_DIS;
      cur_code <= 8'h00;
      sw_en_q  <= 1'b0;
      en_src_q <= 1'b0;
    end else begin
      state    <= next_state;
      cur_code <= next_code;
      sw_en_q  <= ctrl.sw_enable;
      en_src_q <= en_src;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= 8'h00;
      end
    end else if (fault_take) begin
      hist[0] <= next_code; // [RL3]
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // ---------------- drive-side outputs, taken from the next state so a fault acts at once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      power_stage_en        <= 1'b0;
      enable_lamp           <= 1'b0;
      fault_display_pattern <= '0;
    end else begin
      power_stage_en                   <= next_state == DFG_EN; // [RL1] [RL15]
      enable_lamp                      <= next_state == DFG_EN; // [RL1]
      fault_display_pattern.show_fault <= ctrl.disp_default && next_state == DFG_FLT; // [RL6]
      fault_display_pattern.code       <= next_code; // [RL6]
    end
  end

  for (genvar g = 0; g < NUM_DOUT; g++) begin : g_dout
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        dout[g] <= 1'b0;
      end else begin
        case (docf[2*g +: 2])
          2'b00:   dout[g] <= docf[`DFG_GP_LSB + g];
          2'b01:   dout[g] <= next_state == DFG_FLT; // [RL4]
          2'b10:   dout[g] <= next_state == DFG_EN;  // [RL5]
          default: dout[g] <= 1'b0;
        endcase
      end
    end
  end

  // ---------------- gearing: two cascaded pulse scalers
  // stage 0: master -> system pulses, stage 1: secondary -> primary
  // pending pulses drain one per clock, so input rate times ratio must stay below the clock
  logic [1:0]  st_act;
  logic [1:0]  st_in;
  logic [1:0]  st_in_dir;
  logic [1:0]  st_out;
  logic [1:0]  st_dir;
  logic [16:0] st_num [2];
  logic [15:0] st_den [2];
  logic [23:0] st_rem [2];

  assign st_act[0]    = ctrl.pos_mode && state == DFG_EN; // [RL9] [RL15]
  assign st_act[1]    = st_act[0] && ctrl.dual_loop; // [RL11]
  assign st_in[0]     = master_in.step;
  assign st_in_dir[0] = master_in.dir;
  assign st_in[1]     = st_out[0];
  assign st_in_dir[1] = st_dir[0];
  assign st_num[0]    = {1'b0, gear[`DFG_NUM_LSB +: 16]}; // [RL10]
  assign st_den[0]    = gear[`DFG_DEN_LSB +: 16];
  assign st_num[1]    = ctrl.resolver ? `DFG_RES_PPR : {1'b0, psr[`DFG_NUM_LSB +: 16]}; // [RL13]
  assign st_den[1]    = psr[`DFG_DEN_LSB +: 16]; // [RL12]

  for (genvar s = 0; s < 2; s++) begin : g_stage
    logic drain;
    assign drain = st_rem[s] >= {8'h00, st_den[s]} && st_den[s] != 16'h0000;
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        st_rem[s] <= 24'h00_0000;
        st_out[s] <= 1'b0;
        st_dir[s] <= 1'b0;
      end else if (!st_act[s]) begin
        st_rem[s] <= 24'h00_0000;
        st_out[s] <= 1'b0;
      end else begin
        st_rem[s] <= st_rem[s] + (st_in[s] && st_den[s] != 16'h0000 ? {7'h00, st_num[s]} : 24'h0)
                     - (drain ? {8'h00, st_den[s]} : 24'h00_0000);
        st_out[s] <= drain;
        if (st_in[s]) begin
          st_dir[s] <= st_in_dir[s];
        end
      end
    end
  end

  assign motor_cmd.step = ctrl.dual_loop ? st_out[1] : st_out[0];
  assign motor_cmd.dir  = ctrl.dual_loop ? st_dir[1] : st_dir[0];

  // ---------------- dual loop: secondary error into the integrator
  logic signed [POS_W-1:0] sec_tgt;
  logic signed [POS_W-1:0] sec_pos;
  logic signed [POS_W-1:0] sec_err;
  logic signed [17:0]      acc;
  logic signed [17:0]      next_acc;
  logic signed [17:0]      lim;
  logic signed [16:0]      err_sat;
  logic signed [34:0]      prod;

  assign sec_err = sec_tgt - sec_pos;
  assign lim     = 18'(intg[31:16]);

  always_comb begin
    if (sec_err > 32767) begin
      err_sat = 17'sh0_7FFF;
    end else if (sec_err < -32767) begin
      err_sat = -17'sh0_7FFF;
    end else begin
      err_sat = 17'(sec_err);
    end
    next_acc = acc + 18'(err_sat);
    if (next_acc > lim) begin
      next_acc = lim;
    end else if (next_acc < -lim) begin
      next_acc = -lim;
    end
    prod = 35'(acc) * 35'(intg[15:0]);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_pos <= '0;
    end else if (sec_enc.step) begin
      sec_pos <= sec_enc.dir ? sec_pos - 1 : sec_pos + 1;
    end
  end

  // outside the dual loop the target tracks feedback so the loop starts with no error
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_tgt    <= '0;
      acc        <= '0;
      integ_term <= '0;
    end else if (!st_act[1]) begin
      sec_tgt    <= sec_pos;
      acc        <= '0;
      integ_term <= '0;
    end else begin
      if (st_out[0]) begin
        sec_tgt <= st_dir[0] ? sec_tgt - 1 : sec_tgt + 1;
      end
      acc        <= next_acc; // [RL14]
      integ_term <= POS_W'(prod); // [RL14]
    end
  end

  // ---------------- interrupts, set wins over clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign irq_set[`DFG_IRQ_FLT] = fault_take;
  assign irq_set[`DFG_IRQ_ENA] = next_state == DFG_EN && state != DFG_EN;
  assign irq_set[`DFG_IRQ_DIS] = next_state == DFG_DIS && state != DFG_DIS;
  assign irq_clr = wr_fire && aw_addr == `DFG_IRQC && w_strb[0] ? w_data[2:0] : 3'h0;
  assign irq     = |(irq_stat & irq_en);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  // ---------------- axi read channel
  logic [31:0] rd_val;
  logic        rd_err;
  logic        warn;

  assign warn          = ctrl.dual_loop && (intg[15:0] == 16'h0 || intg[31:16] == 16'h0);
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_err = 1'b0;
    if (s_axi_araddr == `DFG_CTRL) begin
      rd_val = {24'h0, ctrl};
    end else if (s_axi_araddr == `DFG_STAT) begin
      rd_val = {14'h0, state, cur_code, 4'h0, warn, hw_enable_input,
                state == DFG_FLT, state == DFG_EN};
    end else if (s_axi_araddr == `DFG_GEAR) begin
      rd_val = gear;
    end else if (s_axi_araddr == `DFG_PSR) begin
      rd_val = psr;
    end else if (s_axi_araddr == `DFG_HSEL) begin
      rd_val = {29'h0, hsel};
    end else if (s_axi_araddr == `DFG_HIST) begin
      rd_val = 32'(hsel) < HIST_DEPTH ? {24'h0, hist[hsel]} : 32'h0;
    end else if (s_axi_araddr == `DFG_DOCF) begin
      rd_val = docf;
    end else if (s_axi_araddr == `DFG_INTG) begin
      rd_val = intg;
    end else if (s_axi_araddr == `DFG_SPOS) begin
      rd_val = 32'(sec_pos);
    end else if (s_axi_araddr == `DFG_IRQS) begin
      rd_val = {29'h0, irq_stat};
    end else if (s_axi_araddr == `DFG_IRQE) begin
      rd_val = {29'h0, irq_en};
    end else if (s_axi_araddr == `DFG_IRQC) begin
      rd_val = 32'h0;
    end else begin
      rd_val = 32'h0;
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DFG_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_err ? `DFG_SLVERR : `DFG_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- assertions
  sequence s_inh_fault;
    state == DFG_FLT && cur_code == `DFG_INH_CODE;
  endsequence

  a_fault_kills_power: assert property (fault_event |=> !power_stage_en && !enable_lamp) // [RL1]
    else $error("power stage still on after fault");
  a_fault_state_set: assert property (fault_event |=> state == DFG_FLT) // [RL2]
    else $error("fault did not set fault state");
  a_fault_code_logged: assert property (fault_event |=> hist[0] == $past(fault_code)) // [RL3]
    else $error("fault code not logged");
  a_dout_fault_level: assert property (fault_event && docf[1:0] == 2'b01 |=> dout[0]) // [RL4]
    else $error("fault output not asserted");
  a_dout_ready_drop: assert property (fault_event && docf[3:2] == 2'b10 |=> !dout[1]) // [RL5]
    else $error("ready output not deasserted");
  a_display_shows_code: assert property (fault_event && ctrl.disp_default |=> // [RL6]
    fault_display_pattern.show_fault && fault_display_pattern.code == $past(fault_code))
    else $error("display does not show fault code");
  a_reset_on_disable: assert property (state == DFG_FLT && !ctrl.reset_on_enable && !en_src // [RL7]
    && !fault_event |=> state == DFG_DIS)
    else $error("fault not cleared on disable");
  a_fault_holds_off: assert property (state == DFG_FLT |-> !power_stage_en && !enable_lamp) // [RL8]
    else $error("drive on while fault latched");
  a_gear_follow: assert property (st_act[0] && !ctrl.dual_loop && st_den[0] == 16'h1 // [RL10]
    && st_num[0] != 17'h0 && master_in.step && st_rem[0] == 24'h0 ##1 state == DFG_EN
    |=> motor_cmd.step)
    else $error("master pulse not followed");
  a_no_step_disabled: assert property (motor_cmd.step |-> $past(state) == DFG_EN) // [RL15]
    else $error("motor stepped while not enabled");
  a_run_enable: assert property (!inhibit_mode && state == DFG_DIS && hw_enable_input // [RL16]
    && !fault_event |=> state == DFG_EN ##0 power_stage_en)
    else $error("enable input did not enable");
  a_inhibit_refuse: assert property (inhibit_mode && state == DFG_DIS && sw_rise // [RL18]
    && !hw_enable_input && !fault_event |=> s_inh_fault)
    else $error("inhibited enable did not fault");
  a_inhibit_drop: assert property (inhibit_mode && state == DFG_EN && !hw_enable_input // [RL19]
    && !fault_event |=> s_inh_fault ##0 !power_stage_en)
    else $error("inhibit drop did not fault");

endmodule // dfg_ctrl

//--- verification/dfg_partner.sv
`timescale 1ns/100ps
module dfg_partner import dfg_pkg::*; (
  // clock
  input  wire logic ref_clk,
  // pulse source and enable switch
  output dfg_step_t master_in,
  output logic      hw_enable_input
);
  initial begin
    master_in = '0;
    hw_enable_input = 1'b0;
  end
  // a gap after each step so pulses never merge
  task automatic pulse(input int n, input logic d);
    repeat (n) begin
      @(posedge ref_clk);
      master_in <= '{step: 1'b1, dir: d};
      @(posedge ref_clk);
      master_in <= '{step: 1'b0, dir: d};
    end
  endtask
  // the operator supplies the enable request
  task automatic sw(input logic v);
    @(posedge ref_clk);
    hw_enable_input <= v;
  endtask
endmodule // dfg_partner

//--- verification/tb_drive_enable_fault_gearing_ctrl.sv
`timescale 1ns/100ps
`include "dfg_map.svh"
module tb_drive_enable_fault_gearing_ctrl import dfg_pkg::*; ;
  logic        ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, fault_event;
  logic        awready, wready, bvalid, arready, rvalid, pwr, lamp, irq, hw;
  logic [7:0]  awaddr, araddr, fault_code;
  logic [31:0] wdata, rdata, integ, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  dout, wstrb;
  dfg_step_t   master_in, motor_cmd, sec_enc;
  dfg_disp_t   disp;
  int          err_count, total_checks, cyc, steps;

  dfg_partner p (.ref_clk(ref_clk), .master_in(master_in), .hw_enable_input(hw));
  dfg_ctrl i_dut (
    .ref_clk(ref_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_enable_input(hw), .fault_event(fault_event), .fault_code(fault_code),
    .master_in(master_in), .sec_enc(sec_enc),
    .power_stage_en(pwr), .enable_lamp(lamp), .motor_cmd(motor_cmd), .integ_term(integ),
    .dout(dout), .fault_display_pattern(disp), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (motor_cmd.step === 1'b1) steps <= steps + 1;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(negedge ref_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      got = bvalid;
      rs = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, got;
    got = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge ref_clk);
      ta = arvalid & arready;
      got = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
  endtask

  task automatic t_regs();
    rd(`DFG_CTRL, d, r);
    chk(d, 32'h0000_0000);
    rd(`DFG_GEAR, d, r);
    chk(d, 32'h0001_0001);
    // low byte only: the rest of the ratio must survive
    wstrb <= 4'h1;
    wr(`DFG_GEAR, 32'h0005_0007, r);
    wstrb <= 4'hF;
    rd(`DFG_GEAR, d, r);
    chk(d, 32'h0001_0007);
    rd(8'h40, d, r);
    chk({d[29:0], r}, 32'h0000_0002);
    wr(`DFG_STAT, 32'h0000_0001, r);
    chk(32'(r), 32'h0000_0002);
  endtask

  task automatic t_fault();
    wr(`DFG_DOCF, 32'h0000_0009, r);
    wr(`DFG_CTRL, 32'h0000_0080, r);
    wr(`DFG_IRQE, 32'h0000_0001, r);
    settle(1);
    chk(32'(pwr), 32'h0);
    p.sw(1'b1);
    settle(1);
    chk({30'h0, pwr, lamp}, 32'h3);
    chk(32'(dout[1:0]), 32'h2);
    @(posedge ref_clk);
    fault_event <= 1'b1;
    fault_code <= 8'h5A;
    @(posedge ref_clk);
    fault_event <= 1'b0;
    settle(0);
    chk({30'h0, pwr, lamp}, 32'h0);
    chk(32'(dout[1:0]), 32'h1);
    chk(32'(disp), 32'h15A);
    chk(32'(irq), 32'h1);
    settle(6);
    chk(32'(pwr), 32'h0);
    rd(`DFG_HIST, d, r);
    chk(d, 32'h5A);
    rd(`DFG_STAT, d, r);
    chk(32'(d[17:16]), 32'h2);
    wr(`DFG_IRQC, 32'h0000_0001, r);
    settle(1);
    chk(32'(irq), 32'h0);
    p.sw(1'b0);
    settle(1);
    rd(`DFG_STAT, d, r);
    chk(32'(d[17:16]), 32'h0);
  endtask

  task automatic t_inhibit();
    wr(`DFG_CTRL, 32'h0000_0008, r);
    p.sw(1'b1);
    settle(2);
    chk(32'(pwr), 32'h0);
    wr(`DFG_CTRL, 32'h0000_0009, r);
    settle(1);
    chk(32'(pwr), 32'h1);
    p.sw(1'b0);
    settle(1);
    chk(32'(pwr), 32'h0);
    rd(`DFG_STAT, d, r);
    chk(32'(d[17:8]), 32'h224);
    wr(`DFG_CTRL, 32'h0000_0004, r);
    wr(`DFG_CTRL, 32'h0000_0005, r);
    settle(1);
    rd(`DFG_STAT, d, r);
    chk({22'h0, pwr, d[17:8]}, 32'h224);
    // reset on re-enable: input still low, so the fault must hold
    wr(`DFG_CTRL, 32'h0000_0002, r);
    rd(`DFG_STAT, d, r);
    chk(32'(d[17:16]), 32'h2);
    p.sw(1'b1);
    settle(1);
    chk(32'(pwr), 32'h1);
    p.sw(1'b0);
    wr(`DFG_CTRL, 32'h0000_0000, r);
  endtask

  task automatic t_gear();
    wr(`DFG_GEAR, 32'h0001_0002, r);
    wr(`DFG_CTRL, 32'h0000_0010, r);
    p.sw(1'b1);
    settle(1);
    steps = 0;
    p.pulse(3, 1'b0);
    settle(12);
    chk(32'(steps), 32'h6);
    p.sw(1'b0);
  endtask

  // resolver primary 65536 over secondary 32768, gear 2:1, so 1 master pulse gives 4
  task automatic t_dual();
    wr(`DFG_INTG, 32'h0010_0003, r);
    wr(`DFG_PSR, 32'h8000_0001, r);
    wr(`DFG_CTRL, 32'h0000_0070, r);
    p.sw(1'b1);
    settle(2);
    steps = 0;
    p.pulse(1, 1'b0);
    repeat (4) begin
      @(posedge ref_clk);
      sec_enc <= '{step: 1'b1, dir: 1'b0};
      @(posedge ref_clk);
      sec_enc <= '0;
    end
    settle(30);
    chk(32'(steps), 32'h4);
    // error 2 - 4 saturates at limit 16, times gain 3
    chk(integ, 32'hFFFF_FFD0);
    rd(`DFG_SPOS, d, r);
    chk(d, 32'h4);
    p.sw(1'b0);
    settle(2);
    chk(integ, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, fault_event} = '0;
    {awaddr, araddr, fault_code, wdata} = '0;
    {err_count, total_checks, cyc, steps} = '0;
    wstrb = 4'hF;
    sec_enc = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_fault();
    t_inhibit();
    t_gear();
    t_dual();
    report_and_stop();
  end
endmodule // tb_drive_enable_fault_gearing_ctrl
